//--- hdl/ssl_serial_synth.sv
// ssl_serial_synth: three-wire serial load port, latch bank, power-down
// control, dual-modulus feedback divider, reference divider and mux pin.
// assumes serial pins and chip enable are asynchronous to ref_clk_i, while
// rf_tick_i, ref_tick_i and lock_i are single-cycle or level signals from
// logic on ref_clk_i; the serial clock must stay well under ref_clk_i / 6.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - each serial clock rise shifts valid data into the 24-bit register.
// - a load strobe rise copies the word into exactly one of four latches.
// - select 00 control, 01 reference, 10 feedback, 11 test latch.
// - the mux output pin shows lock, divided feedback or divided reference.
// - chip enable low powers down and three-states the charge pump output.
// - chip enable high powers up only if the power-down bits allow it.
// - power-down disconnects the reference input and closes the shunt.
// - the prescaler divides by 8/9, 16/17 or 32/33 as programmed.
// - the prescaler extends a synchronous 4/5 core to the chosen modulus.
// - feedback division is B times P plus A, A steering the modulus.
// - B is a 13-bit counter for 3 to 8191, A a 5-bit counter for 0 to 31.
module ssl_serial_synth (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // serial programming pins
  input wire logic ser_clk_i,
  input wire logic ser_data_i,
  input wire logic load_strobe_i,
  input wire logic chip_enable_i,
  // internal event sources
  input wire logic rf_tick_i,
  input wire logic ref_tick_i,
  input wire logic lock_i,
  // pins and status
  output logic mux_output_pin_o,
  output logic charge_pump_output_oe_o,
  output logic ref_input_conn_o,
  output logic ref_shunt_switch_o,
  output logic powered_down_o,
  output logic fb_div_o,
  // latch contents
  output logic [ssl_pkg::WORD_W-1:0] ctrl_latch_o,
  output logic [ssl_pkg::WORD_W-1:0] rcnt_latch_o,
  output logic [ssl_pkg::WORD_W-1:0] ncnt_latch_o,
  output logic [ssl_pkg::WORD_W-1:0] test_latch_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [ssl_pkg::SYNC_W-1:0] sclk_sy;
    logic [ssl_pkg::SYNC_W-1:0] sdat_sy;
    logic [ssl_pkg::SYNC_W-1:0] le_sy;
    logic [ssl_pkg::SYNC_W-1:0] ce_sy;
    logic sclk_lvl;
    logic le_lvl;
    logic ce_lvl;
    logic [ssl_pkg::WORD_W-1:0] sreg;
    logic [ssl_pkg::WORD_W-1:0] ctrl;
    logic [ssl_pkg::WORD_W-1:0] rlat;
    logic [ssl_pkg::WORD_W-1:0] nlat;
    logic [ssl_pkg::WORD_W-1:0] tlat;
    logic [2:0] core_cnt;
    logic [2:0] ext_cnt;
    logic [ssl_pkg::A_W-1:0] a_cnt;
    logic [ssl_pkg::B_W-1:0] b_cnt;
    logic fb_div;
    logic [ssl_pkg::R_W-1:0] r_cnt;
    logic ref_div;
    logic mux;
    logic pd;
  } ssl_state_t;

  ssl_state_t st_r;
  ssl_state_t st_nxt;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // filtered level follows the pin only when stages two and three agree
  function automatic logic ssl_filt(input logic [2:0] sy, input logic lvl);
    ssl_filt = (sy[1] == sy[2]) ? sy[2] : lvl;
  endfunction

  // core cycles per prescaler output, minus one: P/4 - 1
  function automatic logic [2:0] ssl_ext_last(input logic [1:0] pre);
    unique case (pre)
      ssl_pkg::PRE_8: ssl_ext_last = 3'h1;
      ssl_pkg::PRE_16: ssl_ext_last = 3'h3;
      default: ssl_ext_last = 3'h7;
    endcase
  endfunction

  logic sclk_f;
  logic le_f;
  logic [1:0] pre_sel;
  logic [1:0] pd_bits;
  logic [1:0] mux_sel;
  logic [2:0] ext_last;
  logic mod_hi;
  logic core_last;
  logic pre_out;

  assign pre_sel = st_r.ctrl[ssl_pkg::PRE_LSB +: ssl_pkg::PRE_W];
  assign pd_bits = st_r.ctrl[ssl_pkg::PD_LSB +: ssl_pkg::PD_W];
  assign mux_sel = st_r.ctrl[ssl_pkg::MUX_LSB +: ssl_pkg::MUX_W];
  assign ext_last = ssl_ext_last(pre_sel);
  // the extra core count is spent in the last core cycle of an output
  assign mod_hi = (st_r.a_cnt != '0) && (st_r.ext_cnt == ext_last);
  assign core_last = st_r.core_cnt ==
    (mod_hi ? ssl_pkg::CORE_HI_LAST : ssl_pkg::CORE_LO_LAST);
  assign pre_out = rf_tick_i && !st_r.pd && core_last
    && (st_r.ext_cnt == ext_last);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    sclk_f = ssl_filt(st_r.sclk_sy, st_r.sclk_lvl);
    le_f = ssl_filt(st_r.le_sy, st_r.le_lvl);

    // pins pass three flops; stage one feeds only stage two
    st_nxt.sclk_sy = {st_r.sclk_sy[1:0], ser_clk_i};
    st_nxt.sdat_sy = {st_r.sdat_sy[1:0], ser_data_i};
    st_nxt.le_sy = {st_r.le_sy[1:0], load_strobe_i};
    st_nxt.ce_sy = {st_r.ce_sy[1:0], chip_enable_i};
    st_nxt.sclk_lvl = sclk_f;
    st_nxt.le_lvl = le_f;
    st_nxt.ce_lvl = ssl_filt(st_r.ce_sy, st_r.ce_lvl);

    // data seen with the same latency as the clock edge; the oldest bit
    // falls off the top, so only the newest 24 stay
    if (sclk_f && !st_r.sclk_lvl) begin
      st_nxt.sreg = {st_r.sreg[ssl_pkg::WORD_W-2:0], st_r.sdat_sy[2]};
    end

    if (le_f && !st_r.le_lvl) begin
      unique case (st_r.sreg[ssl_pkg::SEL_HI:ssl_pkg::SEL_LO])
        ssl_pkg::SEL_CTRL: st_nxt.ctrl = st_r.sreg;
        ssl_pkg::SEL_RCNT: st_nxt.rlat = st_r.sreg;
        ssl_pkg::SEL_NCNT: st_nxt.nlat = st_r.sreg;
        ssl_pkg::SEL_TEST: st_nxt.tlat = st_r.sreg;
      endcase
    end

    // any nonzero power-down field overrides chip enable high
    st_nxt.pd = !st_r.ce_lvl || (pd_bits != '0);

    // dual-modulus prescaler
    if (rf_tick_i && !st_r.pd) begin
      if (core_last) begin
        st_nxt.core_cnt = '0;
        st_nxt.ext_cnt = (st_r.ext_cnt == ext_last) ? 3'h0
          : st_r.ext_cnt + 3'h1;
      end else begin
        st_nxt.core_cnt = st_r.core_cnt + 3'h1;
      end
    end

    // swallow and main counters; reload on the B terminal count
    if (pre_out) begin
      if (st_r.b_cnt <= 13'h0001) begin
        st_nxt.b_cnt = st_r.nlat[ssl_pkg::B_LSB +: ssl_pkg::B_W];
        st_nxt.a_cnt = st_r.nlat[ssl_pkg::A_LSB +: ssl_pkg::A_W];
        st_nxt.fb_div = !st_r.fb_div;
      end else begin
        st_nxt.b_cnt = st_r.b_cnt - 13'h0001;
        if (st_r.a_cnt != '0) begin
          st_nxt.a_cnt = st_r.a_cnt - 5'h01;
        end
      end
    end

    // reference divider feeds the mux only
    if (ref_tick_i && !st_r.pd) begin
      if (st_r.r_cnt <= 14'h0001) begin
        st_nxt.r_cnt = st_r.rlat[ssl_pkg::R_LSB +: ssl_pkg::R_W];
        st_nxt.ref_div = !st_r.ref_div;
      end else begin
        st_nxt.r_cnt = st_r.r_cnt - 14'h0001;
      end
    end

    unique case (mux_sel)
      ssl_pkg::MUX_LOCK: st_nxt.mux = lock_i;
      ssl_pkg::MUX_FB: st_nxt.mux = st_r.fb_div;
      ssl_pkg::MUX_REF: st_nxt.mux = st_r.ref_div;
      default: st_nxt.mux = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= '0;
      st_r.ctrl <= ssl_pkg::LATCH_RST;
      st_r.rlat <= ssl_pkg::LATCH_RST;
      st_r.nlat <= ssl_pkg::LATCH_RST;
      st_r.tlat <= ssl_pkg::LATCH_RST;
      st_r.pd <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from flops
  // ---------------------------------------------------------------
  assign mux_output_pin_o = st_r.mux;
  assign charge_pump_output_oe_o = !st_r.pd;
  assign ref_input_conn_o = !st_r.pd;
  assign ref_shunt_switch_o = st_r.pd;
  assign powered_down_o = st_r.pd;
  assign fb_div_o = st_r.fb_div;
  assign ctrl_latch_o = st_r.ctrl;
  assign rcnt_latch_o = st_r.rlat;
  assign ncnt_latch_o = st_r.nlat;
  assign test_latch_o = st_r.tlat;

endmodule
`default_nettype wire

//--- pkg/ssl_pkg.sv
// ssl_pkg: constants shared by the synthesizer serial load and divider.
// assumes one clock domain; field positions inside latches are local picks.
package ssl_pkg;
  // ---------------------------------------------------------------
  // serial word
  // ---------------------------------------------------------------
  localparam int WORD_W = 24;
  localparam int SEL_LO = 0;
  localparam int SEL_HI = 1;
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_RCNT = 2'h1;
  localparam logic [1:0] SEL_NCNT = 2'h2;
  localparam logic [1:0] SEL_TEST = 2'h3;
  localparam int SYNC_W = 3;

  // ---------------------------------------------------------------
  // control latch fields
  // ---------------------------------------------------------------
  localparam int MUX_LSB = 5;
  localparam int MUX_W = 2;
  localparam int PD_LSB = 20;
  localparam int PD_W = 2;
  localparam int PRE_LSB = 22;
  localparam int PRE_W = 2;
  localparam logic [1:0] MUX_LOCK = 2'h0;
  localparam logic [1:0] MUX_FB = 2'h1;
  localparam logic [1:0] MUX_REF = 2'h2;
  localparam logic [1:0] PRE_8 = 2'h0;
  localparam logic [1:0] PRE_16 = 2'h1;

  // ---------------------------------------------------------------
  // counter latch fields
  // ---------------------------------------------------------------
  localparam int A_LSB = 2;
  localparam int A_W = 5;
  localparam int B_LSB = 8;
  localparam int B_W = 13;
  localparam int R_LSB = 2;
  localparam int R_W = 14;

  // ---------------------------------------------------------------
  // prescaler core and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] CORE_LO_LAST = 3'h3;
  localparam logic [2:0] CORE_HI_LAST = 3'h4;
  localparam logic [WORD_W-1:0] LATCH_RST = 24'h000000;
endpackage

//--- verif/ssl_serial_synth_monitor.sv
// ssl_monitor: port-level assertions for the serial synth block.
// assumes it is bound to ssl_serial_synth, single ref_clk_i domain.
`timescale 1ns/1ps
`default_nettype none
module ssl_monitor (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // pins
  input wire logic chip_enable_i,
  input wire logic load_strobe_i,
  input wire logic lock_i,
  input wire logic mux_output_pin_o,
  input wire logic charge_pump_output_oe_o,
  input wire logic ref_input_conn_o,
  input wire logic ref_shunt_switch_o,
  input wire logic powered_down_o,
  input wire logic fb_div_o,
  // latches
  input wire logic [ssl_pkg::WORD_W-1:0] ctrl_latch_o,
  input wire logic [ssl_pkg::WORD_W-1:0] rcnt_latch_o,
  input wire logic [ssl_pkg::WORD_W-1:0] ncnt_latch_o,
  input wire logic [ssl_pkg::WORD_W-1:0] test_latch_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  wire logic [1:0] msel =
    ctrl_latch_o[ssl_pkg::MUX_LSB +: ssl_pkg::MUX_W];
  wire logic [1:0] pdb =
    ctrl_latch_o[ssl_pkg::PD_LSB +: ssl_pkg::PD_W];
  pd_pins_a: assert property (
    powered_down_o |-> !charge_pump_output_oe_o && !ref_input_conn_o
    && ref_shunt_switch_o) else $error("pins live in power-down");
  pu_pins_a: assert property (
    !powered_down_o |-> charge_pump_output_oe_o && ref_input_conn_o
    && !ref_shunt_switch_o) else $error("pins wrong when powered up");
  ce_low_pd_a: assert property (
    !chip_enable_i [*7] |-> powered_down_o) else $error("ce low, still up");
  pd_bits_a: assert property (
    (pdb != 2'h0) [*2] |-> powered_down_o) else $error("pd bits ignored");
  latch_hold_a: assert property (
    !load_strobe_i [*6] |-> $stable({ctrl_latch_o, rcnt_latch_o,
    ncnt_latch_o, test_latch_o})) else $error("latch moved, no load");
  one_latch_a: assert property (
    $onehot0({$changed(ctrl_latch_o), $changed(rcnt_latch_o),
    $changed(ncnt_latch_o), $changed(test_latch_o)}))
    else $error("several latches loaded");
  mux_lock_a: assert property (
    msel == ssl_pkg::MUX_LOCK && $past(msel) == ssl_pkg::MUX_LOCK
    && $past(arst_n_i) |-> mux_output_pin_o == $past(lock_i))
    else $error("mux not showing lock");
  mux_fb_a: assert property (
    msel == ssl_pkg::MUX_FB && $past(msel) == ssl_pkg::MUX_FB
    && $past(arst_n_i) |-> mux_output_pin_o == $past(fb_div_o))
    else $error("mux not showing divided feedback");
  mux_zero_a: assert property (
    (msel == 2'h3) [*2] |-> !mux_output_pin_o) else $error("mux not low");
endmodule
bind ssl_serial_synth ssl_monitor u_mon (.ref_clk_i, .arst_n_i,
  .chip_enable_i, .load_strobe_i, .lock_i, .mux_output_pin_o,
  .charge_pump_output_oe_o, .ref_input_conn_o, .ref_shunt_switch_o,
  .powered_down_o, .fb_div_o, .ctrl_latch_o, .rcnt_latch_o, .ncnt_latch_o,
  .test_latch_o);
`default_nettype wire

//--- verif/ssl_host_model.sv
// ssl_host_model: host that shifts words in and pulses the load strobe.
// assumes the bench calls its tasks; drives on ref_clk_i falling edges.
`timescale 1ns/1ps
`default_nettype none
module ssl_host_model (
  // clock
  input wire logic ref_clk_i,
  // serial pins
  output var logic ser_clk_o,
  output var logic ser_data_o,
  output var logic load_strobe_o
);
  initial begin
    ser_clk_o = 1'b0;
    ser_data_o = 1'b0;
    load_strobe_o = 1'b0;
  end
  // data is inverted once hold is over, so a late sample cannot pass
  task automatic shift(input logic [31:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      repeat (2) @(negedge ref_clk_i);
      ser_data_o = w[i];
      repeat (4) @(negedge ref_clk_i);
      ser_clk_o = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      ser_clk_o = 1'b0;
      ser_data_o = ~w[i];
    end
  endtask
  task automatic strobe();
    repeat (4) @(negedge ref_clk_i);
    load_strobe_o = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    load_strobe_o = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- verif/ssl_tb.sv
// testbench: drives the serial synth through the host model.
// assumes rf and ref ticks every cycle, so periods count in cycles.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk_i, arst_n_i, chip_enable_i, rf_tick_i, ref_tick_i, lock_i;
  wire logic ser_clk_i, ser_data_i, load_strobe_i;
  logic mux_output_pin_o, charge_pump_output_oe_o, powered_down_o;
  logic ref_input_conn_o, ref_shunt_switch_o, fb_div_o, fb_seen;
  logic [23:0] ctrl_latch_o, rcnt_latch_o, ncnt_latch_o, test_latch_o;
  int errors, cmp_count, c;
  ssl_host_model host (.ref_clk_i, .ser_clk_o(ser_clk_i),
    .ser_data_o(ser_data_i), .load_strobe_o(load_strobe_i));
  ssl_serial_synth dut (.ref_clk_i, .arst_n_i, .ser_clk_i, .ser_data_i,
    .load_strobe_i, .chip_enable_i, .rf_tick_i, .ref_tick_i, .lock_i,
    .mux_output_pin_o, .charge_pump_output_oe_o, .ref_input_conn_o,
    .ref_shunt_switch_o, .powered_down_o, .fb_div_o, .ctrl_latch_o,
    .rcnt_latch_o, .ncnt_latch_o, .test_latch_o);
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [23:0] w);
    host.shift({8'h00, w}, 24);
    host.strobe();
    repeat (8) @(negedge ref_clk_i);
  endtask
  // cycles until the mux pin next changes
  task automatic per(output int n);
    logic v;
    n = 0;
    v = mux_output_pin_o;
    while (mux_output_pin_o === v) begin
      @(negedge ref_clk_i);
      n++;
      if (n > 3000) begin
        errors++;
        tally_and_finish();
      end
    end
  endtask
  function automatic logic [23:0] ctl(input logic [1:0] pre, pd, ms);
    return {pre, pd, 13'h0000, ms, 5'h00};
  endfunction
  initial begin
    errors = 0;
    cmp_count = 0;
    {arst_n_i, lock_i} = 2'h0;
    {chip_enable_i, rf_tick_i, ref_tick_i} = 3'h7;
    repeat (8) @(negedge ref_clk_i);
    chk(charge_pump_output_oe_o, 0);
    arst_n_i = 1'b1;
    repeat (8) @(negedge ref_clk_i);
    chk(powered_down_o, 0);
    wr(24'h000015);
    chk(rcnt_latch_o, 24'h000015);
    wr(ctl(2'h0, 2'h0, ssl_pkg::MUX_REF));
    chk(rcnt_latch_o, 24'h000015);
    wr(24'h001F16);
    chk(ncnt_latch_o, 24'h001F16);
    repeat (3) per(c);
    chk(c, 5);
    // B=31, A=5 keeps N above P*P-P for every modulus
    for (int p = 0; p < 3; p++) begin
      wr(ctl(p[1:0], 2'h0, ssl_pkg::MUX_FB));
      repeat (3) per(c);
      chk(c, 31 * (8 << p) + 5);
      // the mux pin repeats the divider output one cycle later
      fb_seen = fb_div_o;
      @(negedge ref_clk_i);
      chk(mux_output_pin_o, fb_seen);
    end
    $display("divider test done");
    wr(ctl(2'h0, 2'h0, ssl_pkg::MUX_LOCK));
    lock_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    chk(mux_output_pin_o, 1);
    wr(ctl(2'h0, 2'h0, 2'h3));
    chk(mux_output_pin_o, 0);
    wr(24'hABCDE7);
    chk(test_latch_o, 24'hABCDE7);
    chk(ctrl_latch_o, ctl(2'h0, 2'h0, 2'h3));
    host.shift(32'hA5123455, 32);
    host.strobe();
    repeat (8) @(negedge ref_clk_i);
    chk(rcnt_latch_o, 24'h123455);
    $display("load test done");
    chip_enable_i = 1'b0;
    repeat (8) @(negedge ref_clk_i);
    chk(powered_down_o, 1);
    chk(ref_input_conn_o, 0);
    chip_enable_i = 1'b1;
    repeat (8) @(negedge ref_clk_i);
    chk(ref_shunt_switch_o, 0);
    wr(ctl(2'h0, 2'h1, 2'h0));
    chk(powered_down_o, 1);
    $display("power test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
